// file: inc/tqs_pkg.sv
// Constants shared by the transmit equalizer store and recall block
package tqs_pkg;
    localparam int          LANES        = 8;
    localparam int          EQ_W         = 8;
    localparam int          BUF_W        = 4;
    localparam logic [3:0]  BUF_COUNT    = 4'h4;
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    // Register offsets
    localparam logic [7:0]  REG_CAP      = 8'h00;
    localparam logic [7:0]  REG_ENABLE   = 8'h04;
    localparam logic [7:0]  REG_HOLD     = 8'h08;
    localparam logic [7:0]  REG_OVERRIDE = 8'h0C;
    localparam logic [7:0]  REG_PATH_OK  = 8'h10;
    localparam logic [7:0]  REG_STORE    = 8'h14;
    localparam logic [7:0]  REG_RECALL0  = 8'h18;
    localparam logic [7:0]  REG_RECALL1  = 8'h1C;
    localparam logic [7:0]  REG_APPLY    = 8'h20;
    localparam logic [7:0]  REG_STATUS   = 8'h24;
    localparam logic [7:0]  REG_PENDING  = 8'h28;
    localparam logic [7:0]  REG_EQ_BASE  = 8'h40;
    // Apply register field positions
    localparam int          APPLY_REINIT = 0;
    localparam int          APPLY_NOW    = 1;
    localparam int          APPLY_SET    = 2;
    // Cycles an apply keeps a lane marked as busy
    localparam logic [3:0]  CFG_CYCLES   = 4'h4;
    localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_STORE = 3'b010,
        ST_CFG   = 3'b100
    } tqs_state_e;
endpackage

// file: verilog/tqs_store_recall.sv
// Transmit input equalizer store and recall with register port
//
// Function
// RULE1: A read-only capability field reports the number of recall buffers implemented.
// RULE2: Recall buffers are numbered and independent of either staged settings set.
// RULE3: Each recall buffer holds an equalizer value for every lane.
// RULE4: Host writes a buffer number into a lane's store trigger field to capture that lane.
// RULE5: A store halts adaptation on the lane until done, then resumes unless the lane is held.
// RULE6: A store request on a lane whose adaptive enable is clear is ignored.
// RULE7: A store is accepted whenever the lane path is initialized or activated and runs at once; here a request during the lane's store cycle is dropped.
// RULE8: Both staged settings sets carry a per-lane recall selection field.
// RULE9: A read-only per-lane status shows which recalled setting is in effect.
// RULE10: Host writes a buffer number into a staged set's recall selection to recall it.
// RULE11: Recalled values are loaded only on an apply-with-reinit or apply-now of that set.
// RULE12: The recall selection is honoured whatever the host override bit of the lane.
// RULE13: With hold clear the recalled value is the starting point for further adaptation.
// RULE14: With hold set the recalled value stays fixed and adaptation stops.
// RULE15: Adaptive controls are ignored on lanes whose adaptive enable is clear.
// RULE16: Host should see no lane configuring before an apply, or the apply may be dropped.
// RULE17: Buffer numbers of zero or above the count are ignored for store and recall.
`timescale 1ns/1ps
module tqs_store_recall #(
    parameter int         LANES     = tqs_pkg::LANES,
    parameter int         EQ_W      = tqs_pkg::EQ_W,
    parameter logic [3:0] BUF_COUNT = tqs_pkg::BUF_COUNT
) (
    input  wire logic                       ref_clk,
    input  wire logic                       rst_n,
    input  wire logic [tqs_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [tqs_pkg::DATA_W-1:0] regWrData,
    input  wire logic                       regWrite,
    input  wire logic                       regRead,
    output logic      [tqs_pkg::DATA_W-1:0] regRdData,
    input  wire logic [LANES-1:0]           pathReady,
    input  wire logic [LANES*EQ_W-1:0]      adaptedEq,
    output logic      [LANES-1:0]           adaptRun,
    output logic      [LANES-1:0]           eqLoad,
    output logic      [LANES*EQ_W-1:0]      eqLoadValue
);
    localparam int BW    = tqs_pkg::BUF_W;
    localparam int SLOTS = 1 << BW;

    logic [LANES-1:0]      pathSync2;
    logic [LANES*EQ_W-1:0] eqSync2;

    logic [LANES-1:0]    adaptiveEqOn;
    logic [LANES-1:0]    eqAdaptHold;
    logic [LANES-1:0]    hostSiOverride;
    logic [BW-1:0]       eqRecallSelect [2][LANES];
    logic [BW-1:0]       eqRecallStatus [LANES];
    logic [EQ_W-1:0]     recallBuf [SLOTS][LANES];
    wire  logic [LANES-1:0] storeBusy;
    wire  logic [LANES-1:0] storeHit;
    wire  logic [BW-1:0]    storeDest [LANES];
    logic [3:0]          cfgCount;
    logic [LANES-1:0]    configPending;
    logic [tqs_pkg::DATA_W-1:0] rdMux;

    logic                applyHit;
    logic                applySet;
    logic                cfgBusy;
    logic                wrEnable;
    logic                wrHold;
    logic                wrOverride;
    logic                wrRecall0;
    logic                wrRecall1;
    logic                wrStore;
    logic                wrApply;

    // Path status and adapted values come from the lane hardware, outside this clock
    tqs_sync2 #(
        .WIDTH (LANES)
    ) u_tqs_sync2_path (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .din     (pathReady),
        .dout    (pathSync2)
    );

    // A word caught mid-change settles one cycle later; a store takes the settled value
    tqs_sync2 #(
        .WIDTH (LANES*EQ_W)
    ) u_tqs_sync2_eq (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .din     (adaptedEq),
        .dout    (eqSync2)
    );

    function automatic logic bufOk(input logic [BW-1:0] n);
        bufOk = (n != '0) && (n <= BUF_COUNT); // RULE17
    endfunction

    assign cfgBusy  = (cfgCount != 4'h0);
    assign applySet = regWrData[tqs_pkg::APPLY_SET];
    assign applyHit = wrApply && !cfgBusy // RULE16
                      && (regWrData[tqs_pkg::APPLY_REINIT] || regWrData[tqs_pkg::APPLY_NOW]);

    // Write decode
    assign wrEnable   = regWrite && (regAddr == tqs_pkg::REG_ENABLE);
    assign wrHold     = regWrite && (regAddr == tqs_pkg::REG_HOLD);
    assign wrOverride = regWrite && (regAddr == tqs_pkg::REG_OVERRIDE);
    assign wrRecall0  = regWrite && (regAddr == tqs_pkg::REG_RECALL0);
    assign wrRecall1  = regWrite && (regAddr == tqs_pkg::REG_RECALL1);
    assign wrStore    = regWrite && (regAddr == tqs_pkg::REG_STORE);
    assign wrApply    = regWrite && (regAddr == tqs_pkg::REG_APPLY);

    // Adaptive enable per lane
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            adaptiveEqOn <= '0;
        end else if (wrEnable) begin
            adaptiveEqOn <= regWrData[LANES-1:0];
        end
    end

    // Adaptation hold per lane
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            eqAdaptHold <= '0;
        end else if (wrHold) begin
            eqAdaptHold <= regWrData[LANES-1:0];
        end
    end

    // Host override is kept for readback only; recall never looks at it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hostSiOverride <= '0;
        end else if (wrOverride) begin
            hostSiOverride <= regWrData[LANES-1:0];
        end
    end

    // Staged recall selections, one nibble per lane
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int s = 0; s < 2; s++) begin
                for (int l = 0; l < LANES; l++) begin
                    eqRecallSelect[s][l] <= '0;
                end
            end
        end else if (regWrite) begin
            for (int l = 0; l < LANES; l++) begin
                if (wrRecall0) begin
                    eqRecallSelect[0][l] <= regWrData[l*BW +: BW]; // RULE8 RULE10
                end
                if (wrRecall1) begin
                    eqRecallSelect[1][l] <= regWrData[l*BW +: BW]; // RULE8
                end
            end
        end
    end

    // Per-lane store sequencer: a request halts the lane for two cycles; its buffer is written in the one store cycle
    for (genvar g = 0; g < LANES; g++) begin : gen_lane
        tqs_pkg::tqs_state_e laneState;
        tqs_pkg::tqs_state_e next_laneState;
        logic [BW-1:0]       storeNibble;
        logic [BW-1:0]       laneDest;
        logic                laneReq;

        assign storeNibble = regWrData[g*BW +: BW];
        assign laneReq     = wrStore // RULE4
                             && bufOk(storeNibble) // RULE17
                             && adaptiveEqOn[g] // RULE6 RULE15
                             && pathSync2[g]; // RULE7

        always_comb begin
            next_laneState = laneState;
            case (laneState)
                tqs_pkg::ST_IDLE: begin
                    if (laneReq) begin
                        next_laneState = tqs_pkg::ST_STORE;
                    end
                end
                tqs_pkg::ST_STORE: begin
                    next_laneState = tqs_pkg::ST_IDLE;
                end
                default: begin
                    next_laneState = tqs_pkg::ST_IDLE;
                end
            endcase
        end

        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                laneState <= tqs_pkg::ST_IDLE;
            end else begin
                laneState <= next_laneState;
            end
        end

        // A request that arrives during the capture cycle is dropped
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                laneDest <= '0;
            end else if (laneState == tqs_pkg::ST_IDLE && laneReq) begin
                laneDest <= storeNibble;
            end
        end

        assign storeBusy[g] = (laneState == tqs_pkg::ST_STORE); // RULE5
        assign storeHit[g]  = laneReq;
        assign storeDest[g] = laneDest;
    end

    // Recall buffers, numbered apart from the staged sets
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int b = 0; b < SLOTS; b++) begin
                for (int l = 0; l < LANES; l++) begin
                    recallBuf[b][l] <= '0;
                end
            end
        end else begin
            for (int l = 0; l < LANES; l++) begin
                if (storeBusy[l]) begin
                    recallBuf[storeDest[l]][l] <= eqSync2[l*EQ_W +: EQ_W]; // RULE2 RULE3
                end
            end
        end
    end

    // Apply: load recalled values into the working equalizer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            eqLoad      <= '0;
            eqLoadValue <= '0;
            for (int l = 0; l < LANES; l++) begin
                eqRecallStatus[l] <= '0;
            end
        end else begin
            eqLoad <= '0;
            for (int l = 0; l < LANES; l++) begin
                // Override bit deliberately not consulted
                if (applyHit && adaptiveEqOn[l] // RULE11 RULE12 RULE15
                    && bufOk(eqRecallSelect[applySet][l])) begin // RULE17
                    eqLoad[l]                    <= 1'b1;
                    eqLoadValue[l*EQ_W +: EQ_W]  <= recallBuf[eqRecallSelect[applySet][l]][l];
                    eqRecallStatus[l]            <= eqRecallSelect[applySet][l]; // RULE9
                end
            end
        end
    end

    // Busy window after an apply; apply triggers during it are dropped
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgCount      <= 4'h0;
            configPending <= '0;
        end else if (applyHit) begin
            cfgCount      <= tqs_pkg::CFG_CYCLES;
            configPending <= '1;
        end else if (cfgBusy) begin
            cfgCount <= cfgCount - 4'h1;
            if (cfgCount == 4'h1) begin
                configPending <= '0;
            end
        end
    end

    // Adaptation runs only when enabled, not held and not storing
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            adaptRun <= '0;
        end else begin
            for (int l = 0; l < LANES; l++) begin
                adaptRun[l] <= adaptiveEqOn[l] && !eqAdaptHold[l] // RULE13 RULE14
                               && !storeBusy[l] && !storeHit[l]; // RULE5
            end
        end
    end

    // Read multiplexer
    always_comb begin
        rdMux = tqs_pkg::ZERO_WORD;
        case (regAddr)
            tqs_pkg::REG_CAP: begin
                rdMux[3:0] = BUF_COUNT; // RULE1
            end
            tqs_pkg::REG_ENABLE: begin
                rdMux[LANES-1:0] = adaptiveEqOn;
            end
            tqs_pkg::REG_HOLD: begin
                rdMux[LANES-1:0] = eqAdaptHold;
            end
            tqs_pkg::REG_OVERRIDE: begin
                rdMux[LANES-1:0] = hostSiOverride;
            end
            tqs_pkg::REG_PATH_OK: begin
                rdMux[LANES-1:0] = pathSync2;
            end
            tqs_pkg::REG_PENDING: begin
                rdMux[LANES-1:0] = configPending;
            end
            tqs_pkg::REG_RECALL0: begin
                for (int l = 0; l < LANES; l++) begin
                    rdMux[l*BW +: BW] = eqRecallSelect[0][l]; // RULE8
                end
            end
            tqs_pkg::REG_RECALL1: begin
                for (int l = 0; l < LANES; l++) begin
                    rdMux[l*BW +: BW] = eqRecallSelect[1][l]; // RULE8
                end
            end
            tqs_pkg::REG_STATUS: begin
                for (int l = 0; l < LANES; l++) begin
                    rdMux[l*BW +: BW] = eqRecallStatus[l]; // RULE9
                end
            end
            default: begin
                for (int l = 0; l < LANES; l++) begin
                    if (regAddr == tqs_pkg::REG_EQ_BASE + 8'(l * 4)) begin
                        rdMux[EQ_W-1:0] = eqLoadValue[l*EQ_W +: EQ_W];
                    end
                end
            end
        endcase
    end

    // Read data stands from the cycle after the strobe until the next read
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= tqs_pkg::ZERO_WORD;
        end else if (regRead) begin
            regRdData <= rdMux;
        end
    end
endmodule

// Two-flop synchroniser for signals from outside the clock domain
module tqs_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule

// file: sim/tqs_lane_model.sv
// Lane equalizer model: adapts toward a target and takes loaded values
`timescale 1ns/1ps
module tqs_lane_model #(
    parameter int LANES = 8,
    parameter int EQ_W  = 8
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic [LANES*EQ_W-1:0] target,
    input  wire logic [LANES-1:0]      adaptRun,
    input  wire logic [LANES-1:0]      eqLoad,
    input  wire logic [LANES*EQ_W-1:0] eqLoadValue,
    output logic      [LANES*EQ_W-1:0] adaptedEq
);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            adaptedEq <= '0;
        end else begin
            for (int i = 0; i < LANES; i++) begin
                if (eqLoad[i]) begin
                    adaptedEq[i*EQ_W +: EQ_W] <= eqLoadValue[i*EQ_W +: EQ_W];
                end else if (adaptRun[i]) begin
                    adaptedEq[i*EQ_W +: EQ_W] <= target[i*EQ_W +: EQ_W];
                end
            end
        end
    end
endmodule

// file: sim/tqs_store_recall_properties.sv
// Port assertions for the store and recall block
`timescale 1ns/1ps
module tqs_checker #(
    parameter int         LANES     = 8,
    parameter int         EQ_W      = 8,
    parameter logic [3:0] BUF_COUNT = 4'h4
) (
    input wire logic                       ref_clk,
    input wire logic                       rst_n,
    input wire logic [tqs_pkg::ADDR_W-1:0] regAddr,
    input wire logic [tqs_pkg::DATA_W-1:0] regWrData,
    input wire logic                       regWrite,
    input wire logic                       regRead,
    input wire logic [tqs_pkg::DATA_W-1:0] regRdData,
    input wire logic [LANES-1:0]           pathReady,
    input wire logic [LANES-1:0]           adaptRun,
    input wire logic [LANES-1:0]           eqLoad,
    input wire logic [LANES*EQ_W-1:0]      eqLoadValue
);
    logic [3:0] sel0;
    logic       hold0;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel0 <= 4'h0;
        end else if (regWrite && regAddr == tqs_pkg::REG_RECALL0) begin
            sel0 <= regWrData[3:0];
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold0 <= 1'b0;
        end else if (regWrite && regAddr == tqs_pkg::REG_HOLD) begin
            hold0 <= regWrData[0];
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence store_req;
        regWrite && regAddr == tqs_pkg::REG_STORE && regWrData[3:0] inside {[4'h1:BUF_COUNT]} && adaptRun[0]
            && pathReady[0] && $past(pathReady[0]) && $past(pathReady[0], 2);
    endsequence
    sequence halt_resume;
        !adaptRun[0] [*2] ##1 adaptRun[0];
    endsequence
    chk_store_halts: assert property (store_req |=> halt_resume)
        else $error("store did not pause and resume adaptation");
    chk_store_zero: assert property (regWrite && regAddr == tqs_pkg::REG_STORE && regWrData[3:0] == 4'h0
        && adaptRun[0] |=> adaptRun[0]) else $error("store to buffer zero acted");
    chk_cap_value: assert property (regRead && regAddr == tqs_pkg::REG_CAP |=> regRdData[3:0] == BUF_COUNT)
        else $error("capability field wrong");
    chk_rd_hold: assert property (!$past(regRead) |-> $stable(regRdData))
        else $error("read data moved without a read");
    chk_load_cause: assert property (eqLoad != '0 |->
        $past(regWrite && regAddr == tqs_pkg::REG_APPLY && regWrData[1:0] != 2'b00)) else $error("load without apply");
    chk_value_quiet: assert property ($changed(eqLoadValue) |-> eqLoad != '0)
        else $error("load value changed without a load");
    chk_bad_recall: assert property (regWrite && regAddr == tqs_pkg::REG_APPLY && !regWrData[2]
        && regWrData[1:0] != 2'b00 && !(sel0 inside {[4'h1:BUF_COUNT]}) |=> !eqLoad[0]) else $error("bad recall loaded");
    chk_hold_stops: assert property (eqLoad[0] && hold0 |=> !adaptRun[0] [*3])
        else $error("held lane adapted after recall");
endmodule
bind tqs_store_recall tqs_checker #(.LANES(LANES), .EQ_W(EQ_W), .BUF_COUNT(BUF_COUNT)) u_tqs_checker (
    .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .pathReady(pathReady), .adaptRun(adaptRun), .eqLoad(eqLoad),
    .eqLoadValue(eqLoadValue));

// file: sim/test_tqs_store_recall.sv
// Self-checking bench for the store and recall block
`timescale 1ns/1ps
module test_tqs_store_recall;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [31:0] regRdData;
    logic [7:0]  pathReady = 8'h00;
    logic [63:0] target = 64'h0;
    logic [63:0] adaptedEq;
    logic [7:0]  adaptRun;
    logic [7:0]  eqLoad;
    logic [63:0] eqLoadValue;
    int          fails = 0;
    int          check_count = 0;
    int          cycles = 0;
    tqs_store_recall u_tqs_store_recall (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .pathReady(pathReady), .adaptedEq(adaptedEq), .adaptRun(adaptRun), .eqLoad(eqLoad),
        .eqLoadValue(eqLoadValue));
    tqs_lane_model u_tqs_lane_model (.ref_clk(ref_clk), .rst_n(rst_n), .target(target),
        .adaptRun(adaptRun), .eqLoad(eqLoad), .eqLoadValue(eqLoadValue), .adaptedEq(adaptedEq));
    always #12.5 ref_clk = ~ref_clk;
    task automatic end_of_test;
        if (fails == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1;
        d = regRdData;
    endtask
    initial begin
        logic [31:0] d;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        target <= {{7{8'h11}}, 8'h5A};
        pathReady <= 8'hFF;
        rd(tqs_pkg::REG_CAP, d);
        chk("cap", 64'(d[3:0]), 64'(tqs_pkg::BUF_COUNT));
        wr(tqs_pkg::REG_ENABLE, 32'h0000_00FF);
        tick(4);
        chk("run", 64'(adaptRun), 64'hFF);
        wr(tqs_pkg::REG_STORE, 32'h0000_0002);
        chk("halt", 64'(adaptRun), 64'hFE);
        tick(2);
        chk("resume", 64'(adaptRun), 64'hFF);
        @(posedge ref_clk);
        target[7:0] <= 8'hC3;
        wr(tqs_pkg::REG_RECALL0, 32'h0000_0002);
        tick(3);
        chk("early", 64'(eqLoad), 64'h0);
        wr(tqs_pkg::REG_APPLY, 32'h0000_0001);
        chk("load", 64'(eqLoad), 64'h01);
        chk("value", 64'(eqLoadValue[7:0]), 64'h5A);
        wr(tqs_pkg::REG_APPLY, 32'h0000_0001);
        chk("drop", 64'(eqLoad), 64'h0);
        rd(tqs_pkg::REG_STATUS, d);
        chk("status", 64'(d[3:0]), 64'h2);
        tick(6);
        chk("restart", 64'(adaptRun), 64'hFF);
        wr(tqs_pkg::REG_HOLD, 32'h0000_0001);
        wr(tqs_pkg::REG_OVERRIDE, 32'h0000_0001);
        wr(tqs_pkg::REG_RECALL1, 32'h0000_0002);
        tick(4);
        wr(tqs_pkg::REG_APPLY, 32'h0000_0006);
        chk("load1", 64'(eqLoad), 64'h01);
        rd(tqs_pkg::REG_PENDING, d);
        chk("pending", 64'(d[7:0]), 64'hFF);
        rd(tqs_pkg::REG_EQ_BASE, d);
        chk("readback", 64'(d[7:0]), 64'h5A);
        tick(3);
        chk("frozen", 64'(adaptRun), 64'hFE);
        wr(tqs_pkg::REG_RECALL0, 32'(tqs_pkg::BUF_COUNT + 4'h1));
        tick(4);
        wr(tqs_pkg::REG_APPLY, 32'h0000_0001);
        chk("bad", 64'(eqLoad), 64'h0);
        wr(tqs_pkg::REG_HOLD, 32'h0000_0000);
        wr(tqs_pkg::REG_ENABLE, 32'h0000_00FE);
        wr(tqs_pkg::REG_STORE, 32'h0000_0003);
        tick(4);
        chk("off", 64'(adaptRun), 64'hFE);
        wr(tqs_pkg::REG_ENABLE, 32'h0000_00FF);
        tick(2);
        wr(tqs_pkg::REG_STORE, 32'h0000_0000);
        chk("zero", 64'(adaptRun), 64'hFF);
        @(posedge ref_clk);
        pathReady <= 8'hFE;
        tick(4);
        wr(tqs_pkg::REG_STORE, 32'h0000_0002);
        chk("nopath", 64'(adaptRun), 64'hFF);
        end_of_test();
    end
endmodule
